// file: rtl/tsim_defs.vh
// Constants for the transmit status and interrupt mask block.
`ifndef TSIM_DEFS_VH
`define TSIM_DEFS_VH

// Register byte addresses.
`define TSIM_ADDR_TXSTAT   4'h0
`define TSIM_ADDR_MASK     4'h4
`define TSIM_ADDR_STATUS   4'h8
`define TSIM_ADDR_CTRL     4'hc
`define TSIM_ADDR_W        4

// Transmit status bits.
`define TSIM_TX_OK_BIT     0
`define TSIM_TX_SIZE_BIT   1
`define TSIM_TX_UNDER_BIT  2
`define TSIM_TX_MONBAD_BIT 3
`define TSIM_TX_W          4

// Interrupt status bits.
`define TSIM_IRQ_W         16
`define TSIM_IRQ_TXBAD_BIT 8
`define TSIM_IRQ_TXEND_BIT 9
`define TSIM_IRQ_DESC_BIT  11
`define TSIM_MASK_RSV_BIT  15
`define TSIM_MASK_LIVE     16'h7fff
`define TSIM_ZERO16        16'h0000
`define TSIM_ZERO32        32'h00000000

// Control register field.
`define TSIM_CTRL_INHIB_BIT 0

// AXI response codes.
`define TSIM_RESP_OKAY     2'b00
`define TSIM_RESP_SLVERR   2'b10

`endif

// file: rtl/tsim_txstat.v
// Transmit status flag logic for one packet at a time.
`timescale 1ns/100ps
`default_nettype none
`include "tsim_defs.vh"
module tsim_txstat (
    // Clock and reset.
    input  wire                   clk_sys,
    input  wire                   reset,
    // Transmit engine events.
    input  wire                   tx_start,
    input  wire                   tx_done,
    input  wire                   too_many_collisions,
    input  wire                   too_long_deferral,
    input  wire                   fifo_empty_no_bus,
    input  wire [15:0]            tx_packet_size_field,
    input  wire [15:0]            frag_size_sum,
    input  wire                   size_check,
    // Monitor receive path.
    input  wire                   crc_generation_inhibit,
    input  wire                   mon_align_err,
    input  wire                   mon_sa_nomatch,
    input  wire                   mon_frame_end,
    // Results.
    output reg  [`TSIM_TX_W-1:0]  tx_status_r,
    output reg                    tx_abort_r,
    output reg                    tx_ok_pulse_r,
    output reg                    tx_err_pulse_r
);
    reg [`TSIM_TX_W-1:0] tx_status_nxt;
    reg                  mismatch;
    reg                  err_any;

    // Status is cleared at each packet start and built up while it runs.
    always @* begin
        tx_status_nxt = tx_status_r;
        mismatch      = size_check && (tx_packet_size_field != frag_size_sum);
        if (tx_start) begin
            tx_status_nxt = {`TSIM_TX_W{1'b0}};
        end
        // The receive checker watches our own frame; its verdict lands here.
        if (mon_frame_end && (mon_align_err || mon_sa_nomatch) && !crc_generation_inhibit) begin
            tx_status_nxt[`TSIM_TX_MONBAD_BIT] = 1'b1;
        end
        if (crc_generation_inhibit) begin
            tx_status_nxt[`TSIM_TX_MONBAD_BIT] = 1'b0;
        end
        if (fifo_empty_no_bus) begin
            tx_status_nxt[`TSIM_TX_UNDER_BIT] = 1'b1;
        end
        if (mismatch) begin
            tx_status_nxt[`TSIM_TX_SIZE_BIT] = 1'b1;
        end
        err_any = too_many_collisions || too_long_deferral
                || tx_status_nxt[`TSIM_TX_UNDER_BIT] || tx_status_nxt[`TSIM_TX_SIZE_BIT];
        if (tx_done && !err_any) begin
            tx_status_nxt[`TSIM_TX_OK_BIT] = 1'b1;
        end
    end

    // Register the flags and derive one-cycle completion and abort pulses.
    always @(posedge clk_sys) begin
        if (reset) begin
            tx_status_r    <= {`TSIM_TX_W{1'b0}};
            tx_abort_r     <= 1'b0;
            tx_ok_pulse_r  <= 1'b0;
            tx_err_pulse_r <= 1'b0;
        end else begin
            tx_status_r    <= tx_status_nxt;
            tx_abort_r     <= fifo_empty_no_bus || mismatch;
            tx_ok_pulse_r  <= tx_done && !err_any;
            tx_err_pulse_r <= tx_done && err_any;
        end
    end
endmodule
`default_nettype wire

// file: rtl/tsim_irq.v
// Interrupt status register with write-one-to-clear and mask gating.
`timescale 1ns/100ps
`default_nettype none
`include "tsim_defs.vh"
module tsim_irq (
    // Clock and reset.
    input  wire                   clk_sys,
    input  wire                   reset,
    // Event pulses and software access.
    input  wire [`TSIM_IRQ_W-1:0] irq_events,
    input  wire                   clr_we,
    input  wire [`TSIM_IRQ_W-1:0] clr_data,
    input  wire [`TSIM_IRQ_W-1:0] interrupt_enable_mask,
    // Results.
    output reg  [`TSIM_IRQ_W-1:0] interrupt_source_status_r,
    output reg                    irq_r
);
    reg [`TSIM_IRQ_W-1:0] status_nxt;

    // An event in the clearing cycle wins, so no event on bits 14..0 is lost.
    always @* begin
        status_nxt = interrupt_source_status_r;
        if (clr_we) begin
            status_nxt = status_nxt & ~clr_data;
        end
        status_nxt = (status_nxt | irq_events) & `TSIM_MASK_LIVE;
    end

    // The output rises only where a set bit meets an enabled mask bit.
    always @(posedge clk_sys) begin
        if (reset) begin
            interrupt_source_status_r <= `TSIM_ZERO16;
            irq_r                     <= 1'b0;
        end else begin
            interrupt_source_status_r <= status_nxt;
            irq_r <= |(status_nxt & interrupt_enable_mask);
        end
    end
endmodule
`default_nettype wire

// file: rtl/tsim_top.v
// Top of the transmit status and interrupt mask block with its AXI4-Lite slave.
`timescale 1ns/100ps
`default_nettype none
`include "tsim_defs.vh"
module tsim_top (
    // Clock and reset.
    input  wire                     clk_sys,
    input  wire                     reset,
    // AXI4-Lite write address and data.
    input  wire [`TSIM_ADDR_W-1:0]  s_axi_awaddr,
    input  wire                     s_axi_awvalid,
    output reg                      s_axi_awready,
    input  wire [31:0]              s_axi_wdata,
    input  wire [3:0]               s_axi_wstrb,
    input  wire                     s_axi_wvalid,
    output reg                      s_axi_wready,
    // AXI4-Lite write response.
    output reg  [1:0]               s_axi_bresp,
    output reg                      s_axi_bvalid,
    input  wire                     s_axi_bready,
    // AXI4-Lite read.
    input  wire [`TSIM_ADDR_W-1:0]  s_axi_araddr,
    input  wire                     s_axi_arvalid,
    output reg                      s_axi_arready,
    output reg  [31:0]              s_axi_rdata,
    output reg  [1:0]               s_axi_rresp,
    output reg                      s_axi_rvalid,
    input  wire                     s_axi_rready,
    // Transmit engine events, same clock.
    input  wire                     tx_start,
    input  wire                     tx_done,
    input  wire                     too_many_collisions,
    input  wire                     too_long_deferral,
    input  wire                     fifo_empty_no_bus,
    input  wire [15:0]              tx_packet_size_field,
    input  wire [15:0]              frag_size_sum,
    input  wire                     size_check,
    input  wire                     descriptor_irq_request,
    // Monitor receive path, same clock.
    input  wire                     mon_align_err,
    input  wire                     mon_sa_nomatch,
    input  wire                     mon_frame_end,
    // Other interrupt sources, bits 15..0 as status layout, one-cycle pulses.
    input  wire [`TSIM_IRQ_W-1:0]   ext_irq_events,
    // Results.
    output reg                      tx_abort_o,
    output reg                      crc_generation_inhibit,
    output reg                      irq_o
);
    ////////////////////////////////////////////////////////////////////////////////
    reg  [`TSIM_IRQ_W-1:0] interrupt_enable_mask_r;
    reg  [`TSIM_ADDR_W-1:0] awaddr_r;
    reg  [31:0]            wdata_r;
    reg  [3:0]             wstrb_r;
    reg                    aw_got_r;
    reg                    w_got_r;
    reg                    clr_we_r;
    reg  [`TSIM_IRQ_W-1:0] clr_data_r;
    reg  [`TSIM_IRQ_W-1:0] irq_events;
    wire [`TSIM_TX_W-1:0]  tx_status;
    wire                   tx_abort;
    wire                   tx_ok_pulse;
    wire                   tx_err_pulse;
    wire [`TSIM_IRQ_W-1:0] irq_status;
    wire                   irq;
    wire                   wr_go;

    // Merge low byte lanes into a 16-bit register image.
    function [15:0] merge16;
        input [15:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        begin
            merge16 = old_v;
            if (strb[0]) merge16[7:0]  = new_v[7:0];
            if (strb[1]) merge16[15:8] = new_v[15:8];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    tsim_txstat u_txstat (
        .clk_sys                (clk_sys),
        .reset                  (reset),
        .tx_start               (tx_start),
        .tx_done                (tx_done),
        .too_many_collisions    (too_many_collisions),
        .too_long_deferral      (too_long_deferral),
        .fifo_empty_no_bus      (fifo_empty_no_bus),
        .tx_packet_size_field   (tx_packet_size_field),
        .frag_size_sum          (frag_size_sum),
        .size_check             (size_check),
        .crc_generation_inhibit (crc_generation_inhibit),
        .mon_align_err          (mon_align_err),
        .mon_sa_nomatch         (mon_sa_nomatch),
        .mon_frame_end          (mon_frame_end),
        .tx_status_r            (tx_status),
        .tx_abort_r             (tx_abort),
        .tx_ok_pulse_r          (tx_ok_pulse),
        .tx_err_pulse_r         (tx_err_pulse)
    );

    // Our transmit outcomes feed their own status bits; the rest come from outside.
    always @* begin
        irq_events = ext_irq_events;
        irq_events[`TSIM_IRQ_TXEND_BIT] = ext_irq_events[`TSIM_IRQ_TXEND_BIT] | tx_ok_pulse;
        irq_events[`TSIM_IRQ_TXBAD_BIT] = ext_irq_events[`TSIM_IRQ_TXBAD_BIT] | tx_err_pulse;
        irq_events[`TSIM_IRQ_DESC_BIT] = ext_irq_events[`TSIM_IRQ_DESC_BIT]
                                       | descriptor_irq_request;
    end

    tsim_irq u_irq (
        .clk_sys                   (clk_sys),
        .reset                     (reset),
        .irq_events                (irq_events),
        .clr_we                    (clr_we_r),
        .clr_data                  (clr_data_r),
        .interrupt_enable_mask     (interrupt_enable_mask_r),
        .interrupt_source_status_r (irq_status),
        .irq_r                     (irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;

    // Write channel: address and data taken in either order, response after both.
    always @(posedge clk_sys) begin
        if (reset) begin
            s_axi_awready           <= 1'b1;
            s_axi_wready            <= 1'b1;
            s_axi_bvalid            <= 1'b0;
            s_axi_bresp             <= `TSIM_RESP_OKAY;
            aw_got_r                <= 1'b0;
            w_got_r                 <= 1'b0;
            awaddr_r                <= {`TSIM_ADDR_W{1'b0}};
            wdata_r                 <= `TSIM_ZERO32;
            wstrb_r                 <= 4'h0;
            interrupt_enable_mask_r <= `TSIM_ZERO16;
            crc_generation_inhibit  <= 1'b0;
            clr_we_r                <= 1'b0;
            clr_data_r              <= `TSIM_ZERO16;
        end else begin
            clr_we_r <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r      <= s_axi_awaddr;
                aw_got_r      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                w_got_r      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `TSIM_RESP_OKAY;
                case (awaddr_r)
                    `TSIM_ADDR_MASK: begin
                        // Bit 15 is reserved and never stored.
                        interrupt_enable_mask_r <= merge16(interrupt_enable_mask_r, wdata_r,
                            wstrb_r) & `TSIM_MASK_LIVE;
                    end
                    `TSIM_ADDR_STATUS: begin
                        clr_we_r   <= 1'b1;
                        clr_data_r <= merge16(`TSIM_ZERO16, wdata_r, wstrb_r);
                    end
                    `TSIM_ADDR_CTRL: begin
                        if (wstrb_r[0]) begin
                            crc_generation_inhibit <= wdata_r[`TSIM_CTRL_INHIB_BIT];
                        end
                    end
                    `TSIM_ADDR_TXSTAT: begin
                        s_axi_bresp <= `TSIM_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `TSIM_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel: one read at a time, data one cycle after address.
    always @(posedge clk_sys) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `TSIM_ZERO32;
            s_axi_rresp   <= `TSIM_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `TSIM_RESP_OKAY;
                s_axi_rdata   <= `TSIM_ZERO32;
                case (s_axi_araddr)
                    `TSIM_ADDR_TXSTAT: s_axi_rdata[`TSIM_TX_W-1:0] <= tx_status;
                    `TSIM_ADDR_MASK: begin
                        s_axi_rdata[15:0] <= interrupt_enable_mask_r;
                    end
                    `TSIM_ADDR_STATUS: s_axi_rdata[15:0] <= irq_status;
                    `TSIM_ADDR_CTRL: begin
                        s_axi_rdata[`TSIM_CTRL_INHIB_BIT] <= crc_generation_inhibit;
                    end
                    default: s_axi_rresp <= `TSIM_RESP_SLVERR;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // The abort and interrupt outputs are re-registered so each comes straight from a flip-flop.
    always @(posedge clk_sys) begin
        if (reset) begin
            tx_abort_o <= 1'b0;
            irq_o      <= 1'b0;
        end else begin
            tx_abort_o <= tx_abort;
            irq_o      <= irq;
        end
    end
endmodule
`default_nettype wire

// file: testbench/tsim_assertions.sv
// Concurrent checks on the ports of the transmit status block.
`timescale 1ns/100ps
`default_nettype none
module tsim_chk (
    // Clock and reset.
    input wire logic        clk_sys,
    input wire logic        reset,
    // Register bus answers.
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    // Transmit events and results.
    input wire logic        fifo_empty_no_bus,
    input wire logic        size_check,
    input wire logic [15:0] tx_packet_size_field,
    input wire logic [15:0] frag_size_sum,
    input wire logic        tx_abort_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // A size difference only counts while the check strobe is up.
    wire bad_size = size_check && (tx_packet_size_field != frag_size_sum);
    ////////////////////////////////////////////////////////////////////////
    a_underrun_abort: assert property (fifo_empty_no_bus |-> ##2 tx_abort_o)
        else $error("no abort after underrun");
    a_mismatch_abort: assert property (bad_size |-> ##2 tx_abort_o)
        else $error("no abort after size mismatch");
    a_abort_cause: assert property
        (tx_abort_o |-> $past(fifo_empty_no_bus, 2) || $past(bad_size, 2))
        else $error("abort without a cause");
    a_reset_quiet: assert property ($fell(reset) |-> !irq_o && !tx_abort_o)
        else $error("outputs active after reset");
    a_bresp_held: assert property
        (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_bvalid_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    // Main scenarios.
    c_abort: cover property (tx_abort_o);
    c_irq: cover property (irq_o);
    c_slverr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b10);
endmodule
bind tsim_top tsim_chk u_chk (
    .clk_sys, .reset, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .fifo_empty_no_bus, .size_check,
    .tx_packet_size_field, .frag_size_sum, .tx_abort_o, .irq_o
);
`default_nettype wire

// file: testbench/tsim_host.sv
// Host model: an AXI4-Lite master that reads and writes the registers.
`timescale 1ns/100ps
`default_nettype none
module tsim_host (
    // Clock.
    input  wire logic        clk_sys,
    // Write channels.
    output logic [3:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // Read channels.
    output logic [3:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // Idle bus at time zero.
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
    end
    // Write; bready comes late so the slave must hold its answer.
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta;
        logic tw;
        begin
            ta = 1'b0;
            tw = 1'b0;
            @(posedge clk_sys);
            s_axi_awaddr <= a;
            s_axi_wdata <= (a == 4'h4) ? (d & 32'h00007fff) : d;
            s_axi_wstrb <= 4'hf;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            while (!(ta && tw)) begin
                @(posedge clk_sys);
                ta = ta | s_axi_awready;
                tw = tw | s_axi_wready;
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
            end
            // Released payload flips so stale values cannot pass.
            s_axi_awaddr <= ~a;
            s_axi_wdata <= ~d;
            while (!s_axi_bvalid) @(posedge clk_sys);
            s_axi_bready <= 1'b1;
            @(posedge clk_sys);
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask
    // Read with rready offered promptly.
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        begin
            @(posedge clk_sys);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            @(posedge clk_sys);
            while (!s_axi_arready) @(posedge clk_sys);
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
            while (!s_axi_rvalid) @(posedge clk_sys);
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// file: testbench/tx_status_interrupt_mask_tb_top.sv
// Self-checking bench for the transmit status and interrupt mask block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin tests_run = tests_run + 1; if ((a) !== (e)) begin \
    errors = errors + 1; $display("ERROR %s expected %h seen %h", n, e, a); end end
module tx_status_interrupt_mask_tb_top;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic tx_start, tx_done, too_many_collisions, too_long_deferral, fifo_empty_no_bus;
    logic size_check, descriptor_irq_request, mon_align_err, mon_sa_nomatch, mon_frame_end;
    logic tx_abort_o, crc_generation_inhibit, irq_o;
    logic [15:0] tx_packet_size_field, frag_size_sum, ext_irq_events, v;
    integer errors = 0, tests_run = 0, seed = 32'h6780b898, i, c;
    tsim_host host (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    tsim_top uut (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_start, .tx_done,
        .too_many_collisions, .too_long_deferral, .fifo_empty_no_bus, .tx_packet_size_field,
        .frag_size_sum, .size_check, .descriptor_irq_request, .mon_align_err,
        .mon_sa_nomatch, .mon_frame_end, .ext_irq_events, .tx_abort_o,
        .crc_generation_inhibit, .irq_o);
    ////////////////////////////////////////////////////////////////////////
    // Expected transmit status: monitored bad, underrun, mismatch, ok.
    function automatic [15:0] exp_tx(input logic [2:0] k, input logic bad);
        exp_tx = {12'h000, bad, k[0], k[1], k == 3'b000};
    endfunction
    // Expected interrupt status: descriptor, tx ok, tx error.
    function automatic [15:0] exp_st(input logic [2:0] k);
        exp_st = {4'h0, k[0], 1'b0, k == 3'b000, k != 3'b000, 8'h00};
    endfunction
    task tick(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    task rchk(input logic [3:0] a, input logic [15:0] ed);
        begin
            host.rd(a, rv, rr);
            `CHK("rdata", {16'h0000, ed}, rv)
            `CHK("rresp", 2'b00, rr)
        end
    endtask
    task pulse_ext(input logic [15:0] b);
        begin
            @(posedge clk_sys);
            ext_irq_events <= b;
            @(posedge clk_sys);
            ext_irq_events <= 16'h0000;
        end
    endtask
    // One packet: k is underrun, mismatch, collision/deferral; m the monitor errors.
    task pkt(input logic [2:0] k, input logic [1:0] m, input logic [15:0] sz);
        begin
            @(posedge clk_sys);
            tx_start <= 1'b1;
            @(posedge clk_sys);
            tx_start <= 1'b0;
            tx_packet_size_field <= sz;
            frag_size_sum <= k[1] ? sz + 16'h0001 : sz;
            {size_check, fifo_empty_no_bus, descriptor_irq_request} <= {1'b1, k[0], k[0]};
            {mon_align_err, mon_sa_nomatch, mon_frame_end} <= {m, 1'b1};
            @(posedge clk_sys);
            {size_check, fifo_empty_no_bus, descriptor_irq_request} <= 3'b000;
            {mon_align_err, mon_sa_nomatch, mon_frame_end} <= 3'b000;
            {too_many_collisions, too_long_deferral, tx_done} <= {k[2] & sz[0], k[2] & ~sz[0], 1'b1};
            @(posedge clk_sys);
            {too_many_collisions, too_long_deferral, tx_done} <= 3'b000;
            tick(3);
        end
    endtask
    task close_out;
        begin
            $display("Counts: %0d checks, %0d mismatches", tests_run, errors);
            if (errors == 0 && tests_run > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog; the tests need well under ten thousand cycles.
    always #5 clk_sys = ~clk_sys;
    initial begin
        #200000;
        errors = errors + 1;
        close_out;
    end
    // Main sequence.
    initial begin
        {tx_start, tx_done, too_many_collisions, too_long_deferral, fifo_empty_no_bus} = 5'h00;
        {size_check, descriptor_irq_request, mon_align_err, mon_sa_nomatch} = 4'h0;
        {mon_frame_end, tx_packet_size_field, frag_size_sum, ext_irq_events} = 49'h0;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rchk(4'h4, 16'h0000);
        rchk(4'h8, 16'h0000);
        host.wr(4'h2, 32'hffffffff, rr);
        `CHK("bresp", 2'b10, rr)
        host.rd(4'h1, rv, rr);
        `CHK("rresp", 2'b10, rr)
        $display("test reset and unmapped done");
        for (i = 0; i < 6; i = i + 1) begin
            v = $random(seed);
            host.wr(4'h4, {16'hffff, v}, rr);
            `CHK("bresp", 2'b00, rr)
            rchk(4'h4, v & 16'h7fff);
        end
        // A reset in mid-run must clear a mask that holds every live bit.
        host.wr(4'h4, 32'h00007fff, rr);
        rchk(4'h4, 16'h7fff);
        reset <= 1'b1;
        tick(2);
        reset <= 1'b0;
        rchk(4'h4, 16'h0000);
        $display("test mask readback done");
        for (i = 0; i < 15; i = i + 1) begin
            c = (i + 1) % 15;
            host.wr(4'h4, 32'h1 << i, rr);
            pulse_ext(16'h1 << c);
            tick(3);
            `CHK("irq_o", 1'b0, irq_o)
            host.wr(4'h8, 32'h0, rr);
            rchk(4'h8, 16'h1 << c);
            host.wr(4'h8, 32'h1 << c, rr);
            pulse_ext(16'h1 << i);
            tick(3);
            `CHK("irq_o", 1'b1, irq_o)
            host.wr(4'h8, 32'h1 << i, rr);
            tick(2);
            `CHK("irq_o", 1'b0, irq_o)
        end
        $display("test mask gating done");
        for (c = 0; c < 8; c = c + 1) begin
            pkt(c, 2'b00, $random(seed));
            // Writes to the transmit status are answered but change nothing.
            host.wr(4'h0, 32'hffffffff, rr);
            `CHK("bresp", 2'b00, rr)
            rchk(4'h0, exp_tx(c, 1'b0));
            rchk(4'h8, exp_st(c));
            host.wr(4'h8, 32'h0000ffff, rr);
        end
        $display("test transmit status done");
        for (c = 0; c < 6; c = c + 1) begin
            host.wr(4'hc, c / 3, rr);
            `CHK("crc_generation_inhibit", c >= 3, crc_generation_inhibit)
            rchk(4'hc, c / 3);
            pkt(3'b000, (c % 3 == 1) ? 2'b10 : (c % 3 == 2) ? 2'b01 : 2'b00, $random(seed));
            // The flag is read only once the monitored frame has ended.
            rchk(4'h0, exp_tx(3'b000, (c % 3 != 0) && (c < 3)));
        end
        $display("test monitored frame done");
        close_out;
    end
endmodule
`default_nettype wire
